// ===== src/pdp_cfg.svh
/*
 * Addresses, field masks and reset values of the port direction,
 * pull-up option and port data registers.
 * Assumes an 8-bit data path and a 16-bit CPU memory address.
 */
`ifndef PDP_CFG_SVH
`define PDP_CFG_SVH

// ****************************************************************
// Register addresses
// ****************************************************************
`define PDP_ADDR_DIR0 16'hff20
`define PDP_ADDR_DIR1 16'hff21
`define PDP_ADDR_DIR2 16'hff22
`define PDP_ADDR_DIR3 16'hff23
`define PDP_ADDR_DIR5 16'hff25
`define PDP_ADDR_DIR8 16'hff28
`define PDP_ADDR_DIR9 16'hff29
`define PDP_ADDR_PORT0_PULLUP_ENABLE 16'hff30
`define PDP_ADDR_PORT1_PULLUP_ENABLE 16'hff31
`define PDP_ADDR_PORT2_PULLUP_ENABLE 16'hff32
`define PDP_ADDR_PORT3_PULLUP_ENABLE 16'hff33
`define PDP_ADDR_PORT8_PULLUP_ENABLE 16'hff38
`define PDP_ADDR_PORT9_PULLUP_ENABLE 16'hff39
`define PDP_ADDR_LAT3 16'hff03
`define PDP_ADDR_LAT5 16'hff05
`define PDP_ADDR_LAT8 16'hff08
`define PDP_ADDR_LAT9 16'hff09

// ****************************************************************
// Implemented bits of each port
// ****************************************************************
`define PDP_MASK_P0 8'h0f
`define PDP_MASK_P1 8'h03
`define PDP_MASK_P2 8'h07
`define PDP_MASK_P3 8'h0f
`define PDP_MASK_P5 8'h0f
`define PDP_MASK_P8 8'h1f
`define PDP_MASK_P9 8'h3f

// ****************************************************************
// Reset values and register file layout
// ****************************************************************
`define PDP_DIR_RST 8'hff
`define PDP_PUB_RST 8'h00
`define PDP_LAT_RST 8'h00
`define PDP_NREGS 17
`define PDP_FIRST_PUB 5'h07
`define PDP_FIRST_LAT 5'h0d
`define PDP_NO_REG 5'h1f

`endif

// ===== src/pdp_pkg.sv
/*
 * Types shared by the port control block and its bench.
 * Assumes nothing beyond the constants header.
 */
package pdp_pkg;

  // ****************************************************************
  // CPU access request, one per clock
  // ****************************************************************
  typedef struct packed {
    logic [15:0] addr;
    logic wr;
    logic bit_wr;
    logic [2:0] bit_sel;
    logic bit_val;
    logic [7:0] wdata;
  } pdp_bus_req_t;

  // Kind of register selected by an address, one-hot.
  typedef enum logic [3:0] {
    PDP_KIND_NONE = 4'b0001,
    PDP_KIND_DIR = 4'b0010,
    PDP_KIND_PUB = 4'b0100,
    PDP_KIND_LAT = 4'b1000
  } pdp_kind_t;

endpackage

// ===== src/pdp_port_ctrl.sv
/*
 * Port data latches of ports 3, 5, 8 and 9, the direction registers of
 * ports 0, 1, 2, 3, 5, 8 and 9, and the pull-up option registers of ports 0, 1, 2, 3, 8 and 9.
 * Assumes the CPU presents at most one access per clock on bus_req,
 * and that function selects, segment drive and timer outputs come
 * from logic on clk_sys. Pins are asynchronous and are synchronised.
 */
// Overview of operation
// - Port 3 has four latched bits, each with its own direction bit.
// - Reset loads every direction register with all ones: input mode.
// - Port 5 is four open-drain latched bits; pull-up fixed, no register.
// - Port 8 has five latched bits, port use only when function select is 0.
// - Port 9 has six latched bits, port use only when function select is 0.
// - Direction 0 turns the output buffer on, 1 turns it off.
// - One direction bit per pin; unimplemented direction bits read as 1.
// - Direction registers take single-bit and full-byte writes.
// - Every port 3 pin also feeds an interrupt input and a timer path.
// - Pull-up is on only in input mode with its option bit set.
// - Output-mode bits never get a pull-up, whatever the option bit.
// - Pull-up option registers reset to zero, take bit and byte writes.
// - Pull-up registers hold one bit per pin; unused bits read 0.
// - Pull-up option bit 1 connects the pull-up, 0 leaves it off.
// - Function select 1 gives a port 8 or 9 pin to segment output.
// - Segment output drives the pin regardless of direction and latch.
// - Data reads give pin level in input mode, latch in output mode.
`timescale 1ns/10ps
`include "pdp_cfg.svh"

module pdp_port_ctrl (
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire pdp_pkg::pdp_bus_req_t bus_req,
  output logic [7:0] rd_data,
  output logic [3:0] p0_dir,
  output logic [3:0] p0_pullup_en,
  output logic [1:0] p1_dir,
  output logic [1:0] p1_pullup_en,
  output logic [2:0] p2_dir,
  output logic [2:0] p2_pullup_en,
  input wire logic [3:0] p3_pin_in,
  output logic [3:0] p3_pin_out,
  output logic [3:0] p3_pin_oe,
  output logic [3:0] p3_pullup_en,
  input wire logic timer_a_out0,
  input wire logic timer_b0_out,
  output logic ext_irq_in0,
  output logic ext_irq_in1,
  output logic ext_irq_in2,
  output logic ext_irq_in3,
  output logic timer_a_in0,
  output logic timer_a_in1,
  output logic timer_b0_in,
  output logic timer_b1_in,
  input wire logic [3:0] p5_pin_in,
  output logic [3:0] p5_pin_out,
  output logic [3:0] p5_pin_oe,
  input wire logic [4:0] p8_pin_in,
  output logic [4:0] p8_pin_out,
  output logic [4:0] p8_pin_oe,
  output logic [4:0] p8_pullup_en,
  input wire logic [4:0] port8_function_select,
  input wire logic [4:0] p8_seg_in,
  input wire logic [5:0] p9_pin_in,
  output logic [5:0] p9_pin_out,
  output logic [5:0] p9_pin_oe,
  output logic [5:0] p9_pullup_en,
  input wire logic [5:0] port9_function_select,
  input wire logic [5:0] p9_seg_in
);

  // ****************************************************************
  // Address decode and field tables
  // ****************************************************************
  // Index 0..6 direction, 7..12 pull-up option, 13..16 port latches.
  function automatic logic [4:0] addr_index(input logic [15:0] a);
    case (a)
      `PDP_ADDR_DIR0: addr_index = 5'h00;
      `PDP_ADDR_DIR1: addr_index = 5'h01;
      `PDP_ADDR_DIR2: addr_index = 5'h02;
      `PDP_ADDR_DIR3: addr_index = 5'h03;
      `PDP_ADDR_DIR5: addr_index = 5'h04;
      `PDP_ADDR_DIR8: addr_index = 5'h05;
      `PDP_ADDR_DIR9: addr_index = 5'h06;
      `PDP_ADDR_PORT0_PULLUP_ENABLE: addr_index = 5'h07;
      `PDP_ADDR_PORT1_PULLUP_ENABLE: addr_index = 5'h08;
      `PDP_ADDR_PORT2_PULLUP_ENABLE: addr_index = 5'h09;
      `PDP_ADDR_PORT3_PULLUP_ENABLE: addr_index = 5'h0a;
      `PDP_ADDR_PORT8_PULLUP_ENABLE: addr_index = 5'h0b;
      `PDP_ADDR_PORT9_PULLUP_ENABLE: addr_index = 5'h0c;
      `PDP_ADDR_LAT3: addr_index = 5'h0d;
      `PDP_ADDR_LAT5: addr_index = 5'h0e;
      `PDP_ADDR_LAT8: addr_index = 5'h0f;
      `PDP_ADDR_LAT9: addr_index = 5'h10;
      default: addr_index = `PDP_NO_REG;
    endcase
  endfunction

  function automatic pdp_pkg::pdp_kind_t index_kind(input logic [4:0] i);
    if (i < `PDP_FIRST_PUB) begin
      index_kind = pdp_pkg::PDP_KIND_DIR;
    end else if (i < `PDP_FIRST_LAT) begin
      index_kind = pdp_pkg::PDP_KIND_PUB;
    end else if (i < 5'(`PDP_NREGS)) begin
      index_kind = pdp_pkg::PDP_KIND_LAT;
    end else begin
      index_kind = pdp_pkg::PDP_KIND_NONE;
    end
  endfunction

  // Implemented bits of the register at an index.
  function automatic logic [7:0] index_mask(input logic [4:0] i);
    case (i)
      5'h00, 5'h07: index_mask = `PDP_MASK_P0;
      5'h01, 5'h08: index_mask = `PDP_MASK_P1;
      5'h02, 5'h09: index_mask = `PDP_MASK_P2;
      5'h03, 5'h0a, 5'h0d: index_mask = `PDP_MASK_P3;
      5'h04, 5'h0e: index_mask = `PDP_MASK_P5;
      5'h05, 5'h0b, 5'h0f: index_mask = `PDP_MASK_P8;
      5'h06, 5'h0c, 5'h10: index_mask = `PDP_MASK_P9;
      default: index_mask = 8'h00;
    endcase
  endfunction

  function automatic logic [7:0] index_reset(input logic [4:0] i);
    case (index_kind(i))
      pdp_pkg::PDP_KIND_DIR: index_reset = `PDP_DIR_RST;
      pdp_pkg::PDP_KIND_PUB: index_reset = `PDP_PUB_RST;
      default: index_reset = `PDP_LAT_RST;
    endcase
  endfunction

  // ****************************************************************
  // Pin synchronisers
  // ****************************************************************
  // Ports 3, 5, 8, 9 packed low to high; only sync2 is read by logic.
  logic [18:0] sync1_ff;
  logic [18:0] sync2_ff;
  logic [18:0] nxt_sync1;
  logic [18:0] nxt_sync2;

  always_comb begin
    nxt_sync1 = {p9_pin_in, p8_pin_in, p5_pin_in, p3_pin_in};
    nxt_sync2 = sync1_ff;
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      sync1_ff <= 19'h00000;
      sync2_ff <= 19'h00000;
    end else begin
      sync1_ff <= nxt_sync1;
      sync2_ff <= nxt_sync2;
    end
  end

  // ****************************************************************
  // Register file
  // ****************************************************************
  logic [7:0] regs_ff [`PDP_NREGS];
  logic [7:0] nxt_regs [`PDP_NREGS];
  logic [4:0] acc_idx;

  assign acc_idx = addr_index(bus_req.addr);

  // A bit write only touches the selected bit, unlike a CPU
  // read-modify-write, so untouched latch bits of input pins stay put.
  always_comb begin
    logic [7:0] merged;
    logic [7:0] mask;
    merged = 8'h00;
    mask = 8'h00;
    for (int i = 0; i < `PDP_NREGS; i++) begin
      nxt_regs[i] = regs_ff[i];
      if (bus_req.wr && (acc_idx == 5'(i))) begin
        merged = bus_req.wdata;
        if (bus_req.bit_wr) begin
          merged = regs_ff[i];
          merged[bus_req.bit_sel] = bus_req.bit_val;
        end
        mask = index_mask(5'(i));
        if (index_kind(5'(i)) == pdp_pkg::PDP_KIND_DIR) begin
          nxt_regs[i] = merged | ~mask;
        end else begin
          nxt_regs[i] = merged & mask;
        end
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    for (int i = 0; i < `PDP_NREGS; i++) begin
      if (sys_rst) begin
        regs_ff[i] <= index_reset(5'(i));
      end else begin
        regs_ff[i] <= nxt_regs[i];
      end
    end
  end

  // ****************************************************************
  // Read path
  // ****************************************************************
  // Pin levels of each latched port, aligned to bit 0.
  logic [7:0] pin_lvl [4];
  assign pin_lvl[0] = {4'h0, sync2_ff[3:0]};
  assign pin_lvl[1] = {4'h0, sync2_ff[7:4]};
  assign pin_lvl[2] = {3'h0, sync2_ff[12:8]};
  assign pin_lvl[3] = {2'h0, sync2_ff[18:13]};

  // Combinational so a read answers within its access cycle; the
  // price is that rd_data is not a flop and follows bus_req.addr.
  always_comb begin
    logic [4:0] d_idx;
    logic [7:0] dir;
    d_idx = 5'h00;
    dir = 8'h00;
    rd_data = 8'h00;
    case (index_kind(acc_idx))
      pdp_pkg::PDP_KIND_DIR, pdp_pkg::PDP_KIND_PUB: begin
        rd_data = regs_ff[acc_idx];
      end
      pdp_pkg::PDP_KIND_LAT: begin
        d_idx = acc_idx - `PDP_FIRST_LAT;
        dir = regs_ff[d_idx + 5'h03];
        rd_data = ((dir & pin_lvl[d_idx[1:0]]) | (~dir & regs_ff[acc_idx]))
          & index_mask(acc_idx);
      end
      default: rd_data = 8'h00;
    endcase
  end

  // ****************************************************************
  // Pin drive and pull-up control
  // ****************************************************************
  typedef struct packed {
    logic [3:0] p0_dir;
    logic [3:0] p0_pu;
    logic [1:0] p1_dir;
    logic [1:0] p1_pu;
    logic [2:0] p2_dir;
    logic [2:0] p2_pu;
    logic [3:0] p3_out;
    logic [3:0] p3_oe;
    logic [3:0] p3_pu;
    logic [3:0] p3_alt;
    logic [3:0] p5_oe;
    logic [4:0] p8_out;
    logic [4:0] p8_oe;
    logic [4:0] p8_pu;
    logic [5:0] p9_out;
    logic [5:0] p9_oe;
    logic [5:0] p9_pu;
  } pdp_drive_t;

  pdp_drive_t drv_ff;
  pdp_drive_t nxt_drv;
  // Pull-up follows the direction register only: a segment pin keeps
  // its pull-up if the option bit is left set, so software clears it.
  always_comb begin
    nxt_drv.p0_dir = regs_ff[0][3:0];
    nxt_drv.p0_pu = regs_ff[7][3:0] & regs_ff[0][3:0];
    nxt_drv.p1_dir = regs_ff[1][1:0];
    nxt_drv.p1_pu = regs_ff[8][1:0] & regs_ff[1][1:0];
    nxt_drv.p2_dir = regs_ff[2][2:0];
    nxt_drv.p2_pu = regs_ff[9][2:0] & regs_ff[2][2:0];
    // Timer outputs are ORed onto the latch, which software holds at 0.
    nxt_drv.p3_out = regs_ff[13][3:0] | {1'b0, timer_b0_out, 1'b0, timer_a_out0};
    nxt_drv.p3_oe = ~regs_ff[3][3:0];
    nxt_drv.p3_pu = regs_ff[10][3:0] & regs_ff[3][3:0];
    nxt_drv.p3_alt = sync2_ff[3:0];
    // Open drain: only ever pulls low.
    nxt_drv.p5_oe = ~regs_ff[4][3:0] & ~regs_ff[14][3:0];
    for (int b = 0; b < 5; b++) begin
      if (port8_function_select[b]) begin
        nxt_drv.p8_out[b] = p8_seg_in[b];
        nxt_drv.p8_oe[b] = 1'b1;
      end else begin
        nxt_drv.p8_out[b] = regs_ff[15][b];
        nxt_drv.p8_oe[b] = ~regs_ff[5][b];
      end
    end
    nxt_drv.p8_pu = regs_ff[11][4:0] & regs_ff[5][4:0];
    for (int b = 0; b < 6; b++) begin
      if (port9_function_select[b]) begin
        nxt_drv.p9_out[b] = p9_seg_in[b];
        nxt_drv.p9_oe[b] = 1'b1;
      end else begin
        nxt_drv.p9_out[b] = regs_ff[16][b];
        nxt_drv.p9_oe[b] = ~regs_ff[6][b];
      end
    end
    nxt_drv.p9_pu = regs_ff[12][5:0] & regs_ff[6][5:0];
  end

  // Reset value matches the reset registers: all inputs, no pull-ups.
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      drv_ff <= '0;
      drv_ff.p0_dir <= 4'hf;
      drv_ff.p1_dir <= 2'h3;
      drv_ff.p2_dir <= 3'h7;
    end else begin
      drv_ff <= nxt_drv;
    end
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************
  assign p0_dir = drv_ff.p0_dir;
  assign p0_pullup_en = drv_ff.p0_pu;
  assign p1_dir = drv_ff.p1_dir;
  assign p1_pullup_en = drv_ff.p1_pu;
  assign p2_dir = drv_ff.p2_dir;
  assign p2_pullup_en = drv_ff.p2_pu;
  assign p3_pin_out = drv_ff.p3_out;
  assign p3_pin_oe = drv_ff.p3_oe;
  assign p3_pullup_en = drv_ff.p3_pu;
  assign ext_irq_in0 = drv_ff.p3_alt[0];
  assign ext_irq_in1 = drv_ff.p3_alt[1];
  assign ext_irq_in2 = drv_ff.p3_alt[2];
  assign ext_irq_in3 = drv_ff.p3_alt[3];
  assign timer_a_in0 = drv_ff.p3_alt[0];
  assign timer_a_in1 = drv_ff.p3_alt[1];
  assign timer_b0_in = drv_ff.p3_alt[2];
  assign timer_b1_in = drv_ff.p3_alt[3];
  assign p5_pin_out = 4'h0;
  assign p5_pin_oe = drv_ff.p5_oe;
  assign p8_pin_out = drv_ff.p8_out;
  assign p8_pin_oe = drv_ff.p8_oe;
  assign p8_pullup_en = drv_ff.p8_pu;
  assign p9_pin_out = drv_ff.p9_out;
  assign p9_pin_oe = drv_ff.p9_oe;
  assign p9_pullup_en = drv_ff.p9_pu;

endmodule // pdp_port_ctrl

// ===== testbench/pdp_port_monitor.sv
/* Checker for the port control block, watching its top-level ports only.
   Assumes a single clock domain and a synchronous active-high reset. */
`timescale 1ns/10ps
module pdp_port_monitor (
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire pdp_pkg::pdp_bus_req_t bus_req,
  input wire logic [7:0] rd_data,
  input wire logic [3:0] p0_dir,
  input wire logic [3:0] p3_pin_in,
  input wire logic [3:0] p3_pin_oe,
  input wire logic [3:0] p3_pullup_en,
  input wire logic ext_irq_in2,
  input wire logic ext_irq_in3,
  input wire logic timer_b1_in,
  input wire logic [3:0] p5_pin_out,
  input wire logic [4:0] p8_pin_out,
  input wire logic [4:0] p8_pin_oe,
  input wire logic [4:0] port8_function_select,
  input wire logic [4:0] p8_seg_in
);
  // One clock domain, so the clock and the reset guard are shared.
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (sys_rst);

  chk_reset_input:
  assert property (disable iff (1'b0) sys_rst |=> p0_dir == 4'hf && p3_pin_oe == 4'h0)
    else $error("direction not input after reset");
  chk_dir_to_oe:
  assert property (bus_req.wr && !bus_req.bit_wr && bus_req.addr == 16'hff23
    |-> ##2 p3_pin_oe == ~$past(bus_req.wdata[3:0], 2))
    else $error("port 3 buffer does not follow direction write");
  chk_pull_output:
  assert property ((p3_pullup_en & p3_pin_oe) == 4'h0)
    else $error("pull-up on while buffer drives");
  chk_drain_low:
  assert property (p5_pin_out == 4'h0)
    else $error("open-drain port drives high");
  chk_seg_oe:
  assert property (!$past(sys_rst) |-> (p8_pin_oe & $past(port8_function_select))
    == $past(port8_function_select))
    else $error("segment pin not driven");
  chk_seg_level:
  assert property (!$past(sys_rst)
    |-> ((p8_pin_out ^ $past(p8_seg_in)) & $past(port8_function_select)) == 5'h00)
    else $error("segment pin level wrong");
  chk_irq_delay:
  assert property (!$past(sys_rst) && !$past(sys_rst, 2) && !$past(sys_rst, 3)
    |-> ext_irq_in2 == $past(p3_pin_in[2], 3))
    else $error("interrupt input lags pin wrongly");
  chk_pin_shared:
  assert property (timer_b1_in == ext_irq_in3)
    else $error("timer input differs from interrupt input");
  chk_dir_unused:
  assert property (bus_req.addr == 16'hff21 |-> rd_data[7:2] == 6'h3f)
    else $error("unused direction bits not one");
  chk_pub_unused:
  assert property (bus_req.addr == 16'hff39 |-> rd_data[7:6] == 2'h0)
    else $error("unused pull-up bits not zero");
  chk_unmapped_zero:
  assert property (bus_req.addr == 16'hff24 |-> rd_data == 8'h00)
    else $error("unmapped read not zero");
endmodule // pdp_port_monitor

bind pdp_port_ctrl pdp_port_monitor u_mon (.clk_sys, .sys_rst, .bus_req, .rd_data, .p0_dir,
  .p3_pin_in, .p3_pin_oe, .p3_pullup_en, .ext_irq_in2, .ext_irq_in3, .timer_b1_in,
  .p5_pin_out, .p8_pin_out, .p8_pin_oe, .port8_function_select, .p8_seg_in);

// ===== testbench/pdp_pin_model.sv
/* Board model of one port's pins: chip buffer, outside driver, pull-up.
   Assumes the bench chooses which pins the board drives. */
`timescale 1ns/10ps
module pdp_pin_model #(
  parameter int W = 4
) (
  input wire logic clk_sys,
  input wire logic [W-1:0] pin_out,
  input wire logic [W-1:0] pin_oe,
  input wire logic [W-1:0] pin_pull,
  input wire logic [W-1:0] ext_en,
  input wire logic [W-1:0] ext_val,
  output logic [W-1:0] pin_in
);
  logic [W-1:0] float_ff = '0;

  // A floating pin toggles so a stale level can never pass for a real one.
  always @(posedge clk_sys) begin
    float_ff <= ~float_ff;
  end

  // The chip buffer wins, then the board, then the pull-up.
  always_comb begin
    for (int i = 0; i < W; i++) begin
      if (pin_oe[i]) begin
        pin_in[i] = pin_out[i];
      end else if (ext_en[i]) begin
        pin_in[i] = ext_val[i];
      end else if (pin_pull[i]) begin
        pin_in[i] = 1'b1;
      end else begin
        pin_in[i] = float_ff[i];
      end
    end
  end
endmodule // pdp_pin_model

// ===== testbench/pdp_port_ctrl_test.sv
/* Directed bench for the port control block.
   Assumes pin models on ports 3, 5, 8 and 9 and a 10 MHz clock. */
`timescale 1ns/10ps
module pdp_port_ctrl_test;
  logic clk_sys = 1'b0;
  logic sys_rst = 1'b1;
  pdp_pkg::pdp_bus_req_t bus_req = '0;
  logic [7:0] rd_data;
  logic [3:0] p0_dir, p0_pullup_en, p3_pin_in, p3_pin_out, p3_pin_oe, p3_pullup_en;
  logic [1:0] p1_dir, p1_pullup_en;
  logic [2:0] p2_dir, p2_pullup_en;
  logic timer_a_out0 = 1'b0;
  logic timer_b0_out = 1'b0;
  logic ext_irq_in0, ext_irq_in1, ext_irq_in2, ext_irq_in3;
  logic timer_a_in0, timer_a_in1, timer_b0_in, timer_b1_in;
  logic [3:0] p5_pin_in, p5_pin_out, p5_pin_oe;
  logic [4:0] p8_pin_in, p8_pin_out, p8_pin_oe, p8_pullup_en;
  logic [4:0] port8_function_select = '0;
  logic [4:0] p8_seg_in = '0;
  logic [5:0] p9_pin_in, p9_pin_out, p9_pin_oe, p9_pullup_en;
  logic [5:0] port9_function_select = '0;
  logic [5:0] p9_seg_in = '0;
  logic [3:0] x3_en = '0;
  logic [3:0] x3_val = '0;
  logic [3:0] x5_en = '0, x5_val = '0;
  logic [4:0] x8_en = '0, x8_val = '0;
  logic [5:0] x9_en = '0, x9_val = '0;
  int n_mismatch = 0;
  int n_tests = 0;
  int cyc = 0;
  localparam logic [15:0] RA [13] = '{16'hff20, 16'hff21, 16'hff22, 16'hff23, 16'hff25,
    16'hff28, 16'hff29, 16'hff30, 16'hff31, 16'hff32, 16'hff33, 16'hff38, 16'hff39};
  localparam logic [7:0] RM [13] = '{8'h0f, 8'h03, 8'h07, 8'h0f, 8'h0f, 8'h1f, 8'h3f,
    8'h0f, 8'h03, 8'h07, 8'h0f, 8'h1f, 8'h3f};

  pdp_port_ctrl uut (.clk_sys, .sys_rst, .bus_req, .rd_data, .p0_dir, .p0_pullup_en,
    .p1_dir, .p1_pullup_en, .p2_dir, .p2_pullup_en, .p3_pin_in, .p3_pin_out, .p3_pin_oe,
    .p3_pullup_en, .timer_a_out0, .timer_b0_out, .ext_irq_in0, .ext_irq_in1, .ext_irq_in2,
    .ext_irq_in3, .timer_a_in0, .timer_a_in1, .timer_b0_in, .timer_b1_in, .p5_pin_in,
    .p5_pin_out, .p5_pin_oe, .p8_pin_in, .p8_pin_out, .p8_pin_oe, .p8_pullup_en,
    .port8_function_select, .p8_seg_in, .p9_pin_in, .p9_pin_out, .p9_pin_oe,
    .p9_pullup_en, .port9_function_select, .p9_seg_in);
  pdp_pin_model #(.W(4)) pm3 (.clk_sys, .pin_out(p3_pin_out), .pin_oe(p3_pin_oe),
    .pin_pull(p3_pullup_en), .ext_en(x3_en), .ext_val(x3_val), .pin_in(p3_pin_in));
  pdp_pin_model #(.W(4)) pm5 (.clk_sys, .pin_out(p5_pin_out), .pin_oe(p5_pin_oe),
    .pin_pull(4'h0), .ext_en(x5_en), .ext_val(x5_val), .pin_in(p5_pin_in));
  pdp_pin_model #(.W(5)) pm8 (.clk_sys, .pin_out(p8_pin_out), .pin_oe(p8_pin_oe),
    .pin_pull(p8_pullup_en), .ext_en(x8_en), .ext_val(x8_val), .pin_in(p8_pin_in));
  pdp_pin_model #(.W(6)) pm9 (.clk_sys, .pin_out(p9_pin_out), .pin_oe(p9_pin_oe),
    .pin_pull(p9_pullup_en), .ext_en(x9_en), .ext_val(x9_val), .pin_in(p9_pin_in));

  // Clock, and a cycle ceiling well above the roughly 140 cycles the tests need.
  always #50 clk_sys = ~clk_sys;
  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      n_mismatch++;
      summarize();
    end
  end

  // ****************************************************************
  // Bus and compare tasks
  // ****************************************************************
  task automatic chk(string what, logic [7:0] exp, logic [7:0] got);
    n_tests++;
    if (got !== exp) begin
      n_mismatch++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask
  // A write is taken at the edge after it is presented, then the strobe drops.
  task automatic put(pdp_pkg::pdp_bus_req_t r);
    @(posedge clk_sys);
    #10;
    bus_req = r;
    @(posedge clk_sys);
    #10;
    bus_req.wr = 1'b0;
  endtask
  task automatic wr(logic [15:0] a, logic [7:0] d);
    put('{a, 1'b1, 1'b0, 3'h0, 1'b0, d});
  endtask
  task automatic wrb(logic [15:0] a, logic [2:0] s, logic v);
    put('{a, 1'b1, 1'b1, s, v, 8'h00});
  endtask
  // Read data is combinational, so it is sampled mid-cycle with no strobe.
  task automatic rd(string what, logic [15:0] a, logic [7:0] exp);
    @(posedge clk_sys);
    #10;
    bus_req.addr = a;
    #20;
    chk(what, exp, rd_data);
  endtask
  task automatic wait_out(int n);
    repeat (n) @(posedge clk_sys);
    #10;
  endtask
  task automatic summarize();
    $display("checks %0d mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  // Main sequence: each block is one test and ends with a line.
  initial begin
    wait_out(12);
    sys_rst = 1'b0;
    for (int i = 0; i < 13; i++) begin
      rd("reset value", RA[i], i < 7 ? 8'hff : 8'h00);
    end
    chk("p0 dir", 8'h0f, 8'(p0_dir));
    $display("test reset done");
    wr(16'hff24, 8'h5a);
    rd("unmapped", 16'hff24, 8'h00);
    for (int i = 0; i < 13; i++) begin
      wr(RA[i], i < 7 ? 8'h00 : 8'hff);
      rd("byte write", RA[i], i < 7 ? ~RM[i] : RM[i]);
    end
    wait_out(3);
    chk("p3 oe", 8'h0f, 8'(p3_pin_oe));
    chk("p3 pull", 8'h00, 8'(p3_pullup_en));
    chk("p0 pull", 8'h00, 8'(p0_pullup_en));
    chk("p1 dir", 8'h00, 8'(p1_dir));
    chk("p2 dir", 8'h00, 8'(p2_dir));
    chk("p1 p2 pull", 8'h00, 8'({p2_pullup_en, p1_pullup_en}));
    wrb(16'hff23, 3'h1, 1'b1);
    wrb(16'hff33, 3'h2, 1'b0);
    wrb(16'hff33, 3'h7, 1'b1);
    rd("dir3 bit", 16'hff23, 8'hf2);
    rd("port3_pullup_enable bit", 16'hff33, 8'h0b);
    wait_out(3);
    chk("p3 pull bit", 8'h02, 8'(p3_pullup_en));
    chk("p3 oe bit", 8'h0d, 8'(p3_pin_oe));
    $display("test write done");
    wr(16'hff03, 8'h05);
    x3_en = 4'h2;
    wait_out(3);
    chk("p3 out", 8'h05, 8'(p3_pin_out));
    rd("p3 read low", 16'hff03, 8'h05);
    wait_out(1);
    x3_val = 4'h2;
    wait_out(3);
    rd("p3 read high", 16'hff03, 8'h07);
    wr(16'hff03, 8'h00);
    timer_a_out0 = 1'b1;
    timer_b0_out = 1'b1;
    wait_out(5);
    chk("timer out", 8'h05, 8'(p3_pin_out));
    chk("out to irq", 8'h0f, 8'({timer_b0_in, ext_irq_in2, timer_a_in0, ext_irq_in0}));
    timer_a_out0 = 1'b0;
    timer_b0_out = 1'b0;
    wr(16'hff23, 8'hff);
    x3_en = 4'hf;
    x3_val = 4'ha;
    wait_out(5);
    chk("irq in", 8'h0a, 8'({ext_irq_in3, ext_irq_in2, ext_irq_in1, ext_irq_in0}));
    chk("timer in", 8'h0a, 8'({timer_b1_in, timer_b0_in, timer_a_in1, timer_a_in0}));
    rd("p3 pins", 16'hff03, 8'h0a);
    $display("test port3 done");
    wr(16'hff05, 8'h0a);
    wait_out(3);
    chk("p5 oe", 8'h05, 8'(p5_pin_oe));
    rd("p5 read", 16'hff05, 8'h0a);
    wr(16'hff25, 8'hff);
    x5_en = 4'hf;
    x5_val = 4'h9;
    x8_en = 5'h1c;
    x8_val = 5'h14;
    x9_en = 6'h0f;
    x9_val = 6'h05;
    wr(16'hff28, 8'hff);
    wr(16'hff29, 8'hff);
    port8_function_select = 5'h03;
    p8_seg_in = 5'h01;
    port9_function_select = 6'h20;
    p9_seg_in = 6'h20;
    wait_out(3);
    chk("p8 oe", 8'h03, 8'(p8_pin_oe));
    chk("p8 out", 8'h01, 8'(p8_pin_out));
    chk("p9 oe", 8'h20, 8'(p9_pin_oe));
    chk("p9 out", 8'h20, 8'(p9_pin_out));
    chk("p8 pull", 8'h1f, 8'(p8_pullup_en));
    chk("p9 pull", 8'h3f, 8'(p9_pullup_en));
    wr(16'hff38, 8'h1c);
    rd("p5 pins", 16'hff05, 8'h09);
    rd("p8 pins", 16'hff08, 8'h15);
    rd("p9 pins", 16'hff09, 8'h35);
    chk("p8 pull seg", 8'h1c, 8'(p8_pullup_en));
    port8_function_select = 5'h00;
    wr(16'hff08, 8'h1f);
    wr(16'hff28, 8'h00);
    wait_out(3);
    chk("p8 port out", 8'h1f, 8'(p8_pin_out));
    chk("p8 port oe", 8'h1f, 8'(p8_pin_oe));
    chk("p8 pull out", 8'h00, 8'(p8_pullup_en));
    $display("test port589 done");
    sys_rst = 1'b1;
    wait_out(2);
    sys_rst = 1'b0;
    rd("dir3 reset", 16'hff23, 8'hff);
    rd("port9_pullup_enable reset", 16'hff39, 8'h00);
    wait_out(3);
    chk("p3 oe reset", 8'h00, 8'(p3_pin_oe));
    $display("test rereset done");
    summarize();
  end
endmodule // pdp_port_ctrl_test
